// ==== logic/sadc_top.sv ====
/*
 Converter control top: control and result registers, sleep handling,
 pin mode decode, bit period generation and the approximation engine.
 Assumes a plain register port, synchronous pins, and an analog front end
 that samples the selected channel and compares against trial_o.
*/
// Contract
// - Each completed conversion yields an 8-bit unsigned result.
// - Clock select 00/01/10 divides core by 16/8/4; 11 is oscillator by 4.
// - A conversion that is not aborted takes thirteen bit periods.
// - Clock select changes apply only at the next start.
// - Pin select 00 none, 01 two, 10 two and zero, 11 all three.
// - Pin select returns to 11 on any reset.
// - Selected pins are analog with digital output off, enable or not.
// - Channel select 00/01/10 picks input zero/one/two; 11 the reference.
// - Channel writes during a conversion apply after it ends.
// - Writing go starts a conversion; hardware clears it at the end.
// - Clearing go mid-conversion stops at once, keeping the partial result.
// - Go cannot be set while enable is zero.
// - Timing comes only from the core clock; nothing runs in sleep.
// - Sleep clears go and enable, sets clock and channel to 11.
// - After reset or wake all selects read 11, go and enable zero.
// - Result holds through sampling, then clears to zero.
// - Marker shifts in, bits resolve MSB first; nine shifts finish.
// - After abort the marker position tells how many bits resolved.
// - Enable zero powers the converter down.
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_top
   import sadc_pkg::*;
#(
   parameter int ADDR_W = 4
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   input wire logic sleep_i,
   input wire logic int_osc_i,
   input wire logic cmp_i,
   output logic [7:0] trial_o,
   output logic sample_o,
   output logic [1:0] chan_sel_o,
   output logic [2:0] analog_en_o,
   output logic power_on_o
);
   // ==========================================
   // Declarations
   sadc_conv_if cv ();
   logic [1:0] pin_sel;
   logic [1:0] clk_sel;
   logic [1:0] clk_act;
   logic [1:0] chan_wr;
   logic [1:0] chan_act;
   logic go;
   logic enable;
   logic sleep_q;
   logic entering;
   logic waking;
   logic wr_ctrl;
   logic wd_go;
   logic wd_en;
   logic [7:0] ctrl_rd;
   logic tick;
   logic [3:0] tick_n;

   // ==========================================
   // Bus decode
   // Writes are dropped while asleep since the core is halted
   assign wr_ctrl = reg_we_i & (reg_addr_i == ADDR_W'(`SADC_IDX_CTRL)) & ~sleep_i;
   assign wd_go = reg_wdata_i[`SADC_B_GO];
   assign wd_en = reg_wdata_i[`SADC_B_EN];
   assign entering = sleep_i & ~sleep_q;
   assign waking = ~sleep_i & sleep_q;
   assign ctrl_rd = {pin_sel, clk_sel, chan_wr, go, enable};

   // Start needs enable held and written; a restart may ride on completion
   assign cv.start = wr_ctrl & wd_go & wd_en & enable & (~go | cv.done);
   // Software clear, power down or sleep all stop a running conversion
   assign cv.abort = cv.busy & (entering | (wr_ctrl & (~wd_go | ~wd_en)));

   // ==========================================
   // Sleep edge history
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sleep_q <= 1'b0;
      else
         sleep_q <= sleep_i;
   end

   // ==========================================
   // Control register
   // Pin select survives sleep but not wake or reset
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         pin_sel <= 2'(`SADC_CTRL_RST >> `SADC_B_ANS);
      else if (waking)
         pin_sel <= `SADC_SEL_ALL;
      else if (wr_ctrl)
         pin_sel <= reg_wdata_i[`SADC_B_ANS +: 2];
   end

   // Clock select as software sees it
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         clk_sel <= `SADC_SEL_ALL;
      else if (entering | waking)
         clk_sel <= `SADC_SEL_ALL;
      else if (wr_ctrl)
         clk_sel <= reg_wdata_i[`SADC_B_CLK +: 2];
   end

   // Clock source in use, captured only at a start
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         clk_act <= `SADC_SEL_ALL;
      else if (cv.start)
         clk_act <= reg_wdata_i[`SADC_B_CLK +: 2];
   end

   // Channel select as written
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         chan_wr <= `SADC_SEL_ALL;
      else if (entering | waking)
         chan_wr <= `SADC_SEL_ALL;
      else if (wr_ctrl)
         chan_wr <= reg_wdata_i[`SADC_B_CHS +: 2];
   end

   // Channel in use; frozen while a conversion runs
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         chan_act <= `SADC_SEL_ALL;
      else if (entering | waking)
         chan_act <= `SADC_SEL_ALL;
      else if (wr_ctrl & (~cv.busy | cv.done))
         chan_act <= reg_wdata_i[`SADC_B_CHS +: 2];
      else if (~cv.busy)
         chan_act <= chan_wr;
   end

   // Go flag: a start in the completion cycle wins over the clear
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         go <= 1'b0;
      else if (entering | waking)
         go <= 1'b0;
      else if (cv.start)
         go <= 1'b1;
      else if (wr_ctrl & (~wd_go | ~wd_en))
         go <= 1'b0;
      else if (cv.done)
         go <= 1'b0;
   end

   // Enable bit
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         enable <= 1'b0;
      else if (entering | waking)
         enable <= 1'b0;
      else if (wr_ctrl)
         enable <= wd_en;
   end

   // ==========================================
   // Read port: data stand one cycle, zero otherwise
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= `SADC_RD_NONE;
      else if (reg_re_i && (reg_addr_i == ADDR_W'(`SADC_IDX_CTRL)))
         reg_rdata_o <= ctrl_rd;
      else if (reg_re_i && (reg_addr_i == ADDR_W'(`SADC_IDX_RES)))
         reg_rdata_o <= cv.result;
      else
         reg_rdata_o <= `SADC_RD_NONE;
   end

   // ==========================================
   // Pin mode decode, independent of enable
   always_comb
   begin
      unique case (pin_sel)
         2'h0: analog_en_o = `SADC_PINS_NONE;
         2'h1: analog_en_o = `SADC_PINS_TWO;
         2'h2: analog_en_o = `SADC_PINS_TWO_ZERO;
         2'h3: analog_en_o = `SADC_PINS_ALL;
      endcase
   end

   // ==========================================
   // Outputs to the analog front end
   assign power_on_o = enable;
   assign chan_sel_o = chan_act;
   assign sample_o = cv.sampling;
   assign trial_o = cv.result;
   assign cv.tick = tick;

   // ==========================================
   // Bit period clock; gated off in sleep since no other clock exists
   sadc_clkdiv u_clkdiv
   (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .restart_i(cv.start),
      .run_i(cv.busy & ~sleep_i),
      .sel_i(clk_act),
      .osc_i(int_osc_i),
      .tick_o(tick)
   );

   // ==========================================
   // Approximation engine
   sadc_sar u_sar
   (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .cmp_i(cmp_i),
      .cv(cv.sar)
   );

   // ==========================================
   // Checks
   // Helper: bit periods seen in the current conversion
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tick_n <= 4'h0;
      else if (cv.start)
         tick_n <= 4'h0;
      else if (tick & cv.busy)
         tick_n <= tick_n + 4'h1;
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   a_go_needs_enable: assert property ($rose(go) |-> $past(enable))
      else $error("go set while enable was clear");
   a_done_clears_go: assert property (cv.done && !cv.start |=> !go)
      else $error("go still set after completion");
   a_abort_freezes_result: assert property (cv.abort |=> !cv.busy ##1 $stable(trial_o))
      else $error("result moved after abort");
   a_sleep_fields: assert property (entering |=> !go && !enable && clk_sel == 2'h3
      && chan_wr == 2'h3 && pin_sel == $past(pin_sel))
      else $error("sleep entry fields wrong");
   a_wake_fields: assert property (waking |=> ctrl_rd == 8'hFC)
      else $error("wake fields wrong");
   a_chan_held: assert property (cv.busy && !cv.done && !entering |=> $stable(chan_act))
      else $error("channel moved during conversion");
   a_clock_held: assert property (cv.busy && !cv.start |=> $stable(clk_act))
      else $error("clock source moved during conversion");
   a_thirteen_periods: assert property ($rose(cv.done) |-> tick_n == 4'hD)
      else $error("conversion length not thirteen periods");
   a_sample_clear: assert property ($fell(cv.sampling) && cv.busy |-> trial_o == 8'h00)
      else $error("result not cleared after sampling");
   a_sleep_no_tick: assert property (sleep_i && $past(sleep_i) |-> !tick)
      else $error("bit period tick during sleep");
   a_pins_forced: assert property (pin_sel == 2'h3 |-> analog_en_o == 3'h7)
      else $error("pins not forced analog");

   // ==========================================
   // Checks on start, result shifting and completion
   // Go and busy both follow an accepted start
   a_start_sets_go: assert property (cv.start |=> go && cv.busy)
      else $error("start did not raise go");

   // Old result stays readable as sampling begins
   a_start_holds_result: assert property (cv.start |=> cv.sampling && $stable(trial_o))
      else $error("result moved at start");

   // Only a tick of a live conversion may move the result
   a_result_still: assert property (!(tick && cv.busy) |=> $stable(trial_o))
      else $error("result moved without a tick");

   // First tick after the clear plants the marker at the top
   a_marker_enters: assert property (
      cv.busy && !cv.sampling && tick && !cv.abort && trial_o == 8'h00 |=> trial_o == 8'h80)
      else $error("marker not shifted in");

   // Completion leaves the engine idle
   a_done_idle: assert property (cv.done |-> !cv.busy && !cv.sampling)
      else $error("engine busy at completion");

   // No more than thirteen bit periods belong to one conversion
   a_ticks_bounded: assert property (tick_n <= 4'hD)
      else $error("more than thirteen bit periods");

   // ==========================================
   // Checks on enable, sleep and channel
   // Go never stands without enable
   a_go_needs_power: assert property (!enable |-> !go)
      else $error("go set with enable clear");

   // A powered-down converter is idle
   a_off_idle: assert property (!power_on_o |-> !cv.busy)
      else $error("conversion runs while powered down");

   // Nothing converts while the core sleeps
   a_sleep_idle: assert property (sleep_i && $past(sleep_i) |-> !cv.busy)
      else $error("conversion runs in sleep");

   // Between conversions the channel in use is the written one
   a_chan_follows: assert property (!cv.busy |=> chan_sel_o == chan_wr)
      else $error("channel not applied after conversion");

   // Wake returns every pin to analog
   a_wake_pins: assert property (waking |=> analog_en_o == 3'h7)
      else $error("pins not analog after wake");

   // ==========================================
   // Checks on pin decode, one per pin
   a_pin_two: assert property (analog_en_o[2] == (pin_sel != 2'h0))
      else $error("input two analog mode wrong");
   a_pin_one: assert property (analog_en_o[1] == (pin_sel == 2'h3))
      else $error("input one analog mode wrong");
   a_pin_zero: assert property (analog_en_o[0] == pin_sel[1])
      else $error("input zero analog mode wrong");

   // ==========================================
   // Checks on the read port
   // Result reads return the register as it stood
   a_read_result: assert property (reg_re_i && reg_addr_i == ADDR_W'(`SADC_IDX_RES)
      |=> reg_rdata_o == $past(trial_o))
      else $error("result read wrong");

   // Read data stand one cycle only; unmapped reads give zero
   a_read_idle: assert property (!reg_re_i || reg_addr_i > ADDR_W'(`SADC_IDX_RES) |=> reg_rdata_o == 8'h00)
      else $error("read data outside the read cycle");
endmodule // sadc_top

// ==== logic/sadc_params.svh ====
/*
 Register offsets, field positions, reset values and timing counts of
 the converter control block. Assumes inclusion by bare name only.
*/
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
// ==========================================
// Register indexes
`define SADC_IDX_CTRL 4'h0
`define SADC_IDX_RES 4'h1
// ==========================================
// Control field positions (low bit of field)
`define SADC_B_EN 0
`define SADC_B_GO 1
`define SADC_B_CHS 2
`define SADC_B_CLK 4
`define SADC_B_ANS 6
// ==========================================
// Reset and sleep values
`define SADC_CTRL_RST 8'hFC
`define SADC_SEL_ALL 2'h3
`define SADC_RD_NONE 8'h00
`define SADC_PINS_NONE 3'h0
`define SADC_PINS_TWO 3'h4
`define SADC_PINS_TWO_ZERO 3'h5
`define SADC_PINS_ALL 3'h7
// ==========================================
// Timing counts
`define SADC_DIV16_LAST 4'hF
`define SADC_DIV8_LAST 4'h7
`define SADC_DIV4_LAST 4'h3
`define SADC_SAMPLE_END 4'h4
`define SADC_PERIODS 4'hD
`define SADC_MARK_IN 9'h100
`endif

// ==== logic/sadc_pkg.sv ====
/*
 Types shared by the converter control modules.
 Assumes sadc_params.svh supplies the numeric constants.
*/
package sadc_pkg;
   // Gray along idle, sample, convert
   typedef enum logic [1:0] {SADC_IDLE = 2'h0, SADC_SAMPLE = 2'h1, SADC_CONV = 2'h3} sadc_state_e;
   typedef enum logic [1:0] {SADC_CLK_DIV16 = 2'h0, SADC_CLK_DIV8 = 2'h1, SADC_CLK_DIV4 = 2'h2,
      SADC_CLK_OSC4 = 2'h3} sadc_clk_e;
endpackage

// ==== logic/sadc_conv_if.sv ====
/*
 Control to approximation engine signals.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface sadc_conv_if;
   logic start;
   logic abort;
   logic tick;
   logic busy;
   logic done;
   logic sampling;
   logic [7:0] result;
   modport ctl (output start, abort, tick, input busy, done, sampling, result);
   modport sar (input start, abort, tick, output busy, done, sampling, result);
endinterface

// ==== logic/sadc_clkdiv.sv ====
/*
 Bit period tick generator: core clock by 16, 8, 4, or oscillator edges by 4.
 Assumes the oscillator level input is synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_clkdiv
   import sadc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic restart_i,
   input wire logic run_i,
   input wire logic [1:0] sel_i,
   input wire logic osc_i,
   output logic tick_o
);
   logic [3:0] cnt;
   logic [3:0] last;
   logic osc_q;
   logic adv;
   // Divisor terminal count per source
   always_comb
   begin
      unique case (sadc_clk_e'(sel_i))
         SADC_CLK_DIV16: last = `SADC_DIV16_LAST;
         SADC_CLK_DIV8: last = `SADC_DIV8_LAST;
         SADC_CLK_DIV4: last = `SADC_DIV4_LAST;
         SADC_CLK_OSC4: last = `SADC_DIV4_LAST;
      endcase
   end
   assign adv = (sel_i == `SADC_SEL_ALL) ? (osc_i & ~osc_q) : 1'b1;
   // Oscillator edge history
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         osc_q <= 1'b0;
      else
         osc_q <= osc_i;
   end
   // Count and tick; restart aligns periods to the start
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt <= 4'h0;
         tick_o <= 1'b0;
      end
      else if (restart_i)
      begin
         cnt <= 4'h0;
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= run_i & adv & (cnt == last);
         if (run_i & adv)
            cnt <= (cnt == last) ? 4'h0 : cnt + 4'h1;
      end
   end
endmodule // sadc_clkdiv

// ==== logic/sadc_sar.sv ====
/*
 Approximation engine: sampling, clear, leading marker and bit stuffing.
 Assumes ticks arrive one per bit period and the comparator is settled.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_sar
   import sadc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic cmp_i,
   sadc_conv_if.sar cv
);
   sadc_state_e state;
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic [8:0] work;
   logic [8:0] mark;
   assign next_cnt = cnt + 4'h1;
   assign cv.busy = state != SADC_IDLE;
   assign cv.sampling = state == SADC_SAMPLE;
   assign cv.result = work[8:1]; // Marker bit doubles as trial bit
   // Sequence: abort beats start beats tick
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state <= SADC_IDLE;
      else if (cv.abort)
         state <= SADC_IDLE;
      else if (cv.start)
         state <= SADC_SAMPLE;
      else if (cv.tick)
      begin
         unique case (state)
            SADC_IDLE: state <= SADC_IDLE;
            SADC_SAMPLE: if (next_cnt == `SADC_SAMPLE_END) state <= SADC_CONV;
            SADC_CONV: if (next_cnt == `SADC_PERIODS) state <= SADC_IDLE;
            default: state <= SADC_IDLE;
         endcase
      end
   end
   // Bit period count
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt <= 4'h0;
      else if (cv.start)
         cnt <= 4'h0;
      else if (cv.tick & cv.busy)
         cnt <= next_cnt;
   end
   // Completion pulse
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cv.done <= 1'b0;
      else
         cv.done <= cv.tick & ~cv.abort & (state == SADC_CONV) & (next_cnt == `SADC_PERIODS);
   end
   // Result shifting; old result stands through sampling
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         work <= 9'h000;
         mark <= 9'h000;
      end
      else if (cv.start)
         mark <= 9'h000;
      else if (cv.tick & ~cv.abort)
      begin
         if ((state == SADC_SAMPLE) && (next_cnt == `SADC_SAMPLE_END))
            work <= 9'h000;
         else if ((state == SADC_CONV) && (mark == 9'h000))
         begin
            work <= `SADC_MARK_IN;
            mark <= `SADC_MARK_IN;
         end
         else if (state == SADC_CONV)
         begin
            work <= (cmp_i ? work : (work & ~mark)) | (mark >> 1);
            mark <= mark >> 1;
         end
      end
   end
endmodule // sadc_sar

// ==== tb/test_sadc_top.sv ====
/*
 Self-checking bench for the converter control top: register access, pin decode,
 conversion timing and result, abort, sleep and wake.
 Assumes sadc_params.svh and sadc_pkg compiled first; the bench models the comparator.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module test_sadc_top
   import sadc_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic sleep_i = 1'b0;
   logic int_osc_i = 1'b0;
   logic cmp_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [7:0] trial_o;
   logic sample_o;
   logic [1:0] chan_sel_o;
   logic [2:0] analog_en_o;
   logic power_on_o;
   logic [7:0] target = 8'h00;
   logic [7:0] last_res = 8'h00;
   logic [7:0] rd_val;
   int mismatches = 0;
   int n_compared = 0;
   int samp_cnt = 0;
   int samp_len = 0;
   int osc_cnt = 0;

   sadc_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
      .sleep_i(sleep_i), .int_osc_i(int_osc_i), .cmp_i(cmp_i), .trial_o(trial_o), .sample_o(sample_o),
      .chan_sel_o(chan_sel_o), .analog_en_o(analog_en_o), .power_on_o(power_on_o));

   // ==========================================
   // Clock, oscillator and comparator models
   initial
   begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // Slow oscillator: a rising edge every fourteen core cycles
   // Four of them give a 560 ns bit period
   always @(posedge clk_sys_i)
   begin
      osc_cnt <= (osc_cnt == 6) ? 0 : osc_cnt + 1;
      if (osc_cnt == 6)
      begin
         int_osc_i <= ~int_osc_i;
      end
      // Ideal front end; one cycle of lag is harmless as D is at least 4
      cmp_i <= (target >= trial_o);
   end

   // ==========================================
   // Checking and closing
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (mismatches == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Sampling watch: old result held, then cleared when sampling ends
   always @(negedge clk_sys_i)
   begin
      if (sample_o === 1'b1)
      begin
         samp_cnt++;
         check("held_result", 16'(trial_o), 16'(last_res));
      end
      else if (samp_cnt != 0)
      begin
         samp_len = samp_cnt;
         samp_cnt = 0;
         check("cleared_result", 16'(trial_o), 16'h0);
      end
   end

   // ==========================================
   // Register bus tasks and expectations
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_we_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_we_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      reg_re_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_re_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   function automatic int divisor(input logic [1:0] sel);
      return (sel == SADC_CLK_DIV16) ? 16 : (sel == SADC_CLK_DIV8) ? 8 : 4;
   endfunction

   function automatic logic [2:0] pins(input logic [1:0] a);
      return (a == 2'h0) ? 3'h0 : (a == 2'h1) ? 3'h4 : (a == 2'h2) ? 3'h5 : 3'h7;
   endfunction

   // Full conversion, polling go back to back; writes new selects mid-run
   task automatic conv(input logic [1:0] sel, input logic [1:0] ch, input logic [7:0] tgt,
      input logic [1:0] nsel, input logic [1:0] nch);
      int k;
      target = tgt;
      wr(`SADC_IDX_CTRL, {2'h3, sel, ch, 2'h1});
      wr(`SADC_IDX_CTRL, {2'h3, sel, ch, 2'h3});
      reg_re_i <= 1'b1;
      reg_addr_i <= `SADC_IDX_CTRL;
      for (k = 1; k < 1000; k++)
      begin
         @(posedge clk_sys_i);
         reg_re_i <= (k != 9);
         reg_we_i <= (k == 9);
         reg_wdata_i <= {2'h3, nsel, nch, 2'h3}; // Pin select kept mid-run
         #1;
         if (k == 20)
            check("chan_in_run", 16'(chan_sel_o), 16'(ch));
         if (k > 1 && k != 10 && reg_rdata_o[`SADC_B_GO] === 1'b0)
            break;
      end
      @(posedge clk_sys_i);
      reg_re_i <= 1'b0;
      reg_we_i <= 1'b0;
      if (sel != SADC_CLK_OSC4)
      begin
         // Last tick, then the done flop, then the go flop, then the read
         check("conv_cycles", 16'(k), 16'(13 * divisor(sel) + 3));
         check("sample_cycles", 16'(samp_len), 16'(4 * divisor(sel) + 1));
      end
      check("go_cleared", 16'(k < 1000), 16'h1);
      @(posedge clk_sys_i);
      #1;
      check("chan_after", 16'(chan_sel_o), 16'(nch));
      check("final_trial", 16'(trial_o), 16'(tgt));
      rd(`SADC_IDX_RES, rd_val);
      check("result", 16'(rd_val), 16'(tgt));
      last_res = tgt;
   endtask

   // Stop after m resolved bits by clearing go or by entering sleep
   task automatic stop_at(input int m, input logic [7:0] tgt, input bit by_sleep);
      logic [7:0] ex;
      ex = (tgt & ~(8'hFF >> m)) | (8'h80 >> m);
      target = tgt;
      wr(`SADC_IDX_CTRL, by_sleep ? 8'h61 : 8'hE1);
      wr(`SADC_IDX_CTRL, by_sleep ? 8'h63 : 8'hE3);
      repeat (4 * (5 + m) + 1) @(posedge clk_sys_i);
      if (by_sleep)
      begin
         @(posedge clk_sys_i);
         sleep_i <= 1'b1;
      end
      else
         wr(`SADC_IDX_CTRL, 8'hE1);
      repeat (40) @(posedge clk_sys_i);
      #1;
      check("partial", 16'(trial_o), 16'(ex));
      if (by_sleep)
      begin
         check("sleep_power", 16'(power_on_o), 16'h0);
         check("sleep_pins", 16'(analog_en_o), 16'h4);
         wr(`SADC_IDX_CTRL, 8'h03);
         rd(`SADC_IDX_CTRL, rd_val);
         check("sleep_ctrl", 16'(rd_val), 16'h7C);
         @(posedge clk_sys_i);
         sleep_i <= 1'b0;
         rd(`SADC_IDX_CTRL, rd_val);
         check("wake_ctrl", 16'(rd_val), 16'(`SADC_CTRL_RST));
      end
      rd(`SADC_IDX_RES, rd_val);
      check("partial_reg", 16'(rd_val), 16'(ex));
      last_res = ex;
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h2B98));
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(`SADC_IDX_CTRL, rd_val);
      check("reset_ctrl", 16'(rd_val), 16'(`SADC_CTRL_RST));
      check("reset_pins", 16'(analog_en_o), 16'h7);
      check("reset_chan", 16'(chan_sel_o), 16'h3);
      // Pin decode with the converter off
      for (int a = 0; a < 4; a++)
      begin
         wr(`SADC_IDX_CTRL, {2'(a), 6'h00});
         #1;
         check("pins", 16'(analog_en_o), 16'(pins(2'(a))));
         check("power_off", 16'(power_on_o), 16'h0);
      end
      // Go refused while the converter is off
      wr(`SADC_IDX_CTRL, 8'h02);
      rd(`SADC_IDX_CTRL, rd_val);
      check("go_refused", 16'(rd_val), 16'h00);
      wr(`SADC_IDX_CTRL, 8'h03);
      rd(`SADC_IDX_CTRL, rd_val);
      check("go_refused_en", 16'(rd_val), 16'h01);
      check("power_on", 16'(power_on_o), 16'h1);
      wr(`SADC_IDX_RES, 8'h55);
      rd(`SADC_IDX_RES, rd_val);
      check("result_ro", 16'(rd_val), 16'h00);
      rd(4'h5, rd_val);
      check("unmapped", 16'(rd_val), 16'h00);
      // Corner conversions for every clock select, then random ones
      conv(2'h0, 2'h0, 8'h00, 2'h2, 2'h1);
      conv(2'h1, 2'h1, 8'hFF, 2'h0, 2'h2);
      conv(2'h2, 2'h2, 8'hA5, 2'h1, 2'h3);
      conv(2'h3, 2'h3, 8'h5A, 2'h0, 2'h0); // Oscillator source
      repeat (12)
         conv(2'($urandom), 2'($urandom), 8'($urandom), 2'($urandom), 2'($urandom));
      for (int m = 0; m < 8; m++)
         stop_at(m, 8'($urandom), 1'b0);
      stop_at(3, 8'hC9, 1'b1);
      conv(2'h2, 2'h0, 8'h3C, 2'h2, 2'h0);
      finish_test();
   end

   // Watchdog: about twice the worst case of all conversions together
   initial
   begin
      #200000;
      mismatches++;
      finish_test();
   end
endmodule // test_sadc_top
